// File: rtl/nvsc_defs.svh
`ifndef NVSC_DEFS_SVH
`define NVSC_DEFS_SVH

// Operation times, printed units
`define NVSC_CLK_HZ            20000000
`define NVSC_STORE_COM_US      12500
`define NVSC_STORE_IND_US      15000
`define NVSC_POWERUP_MS        20
`define NVSC_SEQ_ACT_US        70
`define NVSC_RECALL_US         50
`define NVSC_HW_DELAY_US       70
`define NVSC_HW_PULSE_NS       15
// Cycle counts derived from the rate (longest times round down)
`define NVSC_US_CYC(us)        (((us) * (`NVSC_CLK_HZ / 1000000)))
`define NVSC_STORE_COM_CYC     `NVSC_US_CYC(`NVSC_STORE_COM_US)
`define NVSC_STORE_IND_CYC     `NVSC_US_CYC(`NVSC_STORE_IND_US)
`define NVSC_POWERUP_CYC       `NVSC_US_CYC(`NVSC_POWERUP_MS * 1000)
`define NVSC_SEQ_ACT_CYC       `NVSC_US_CYC(`NVSC_SEQ_ACT_US)
`define NVSC_RECALL_CYC        `NVSC_US_CYC(`NVSC_RECALL_US)
`define NVSC_HW_DELAY_CYC      `NVSC_US_CYC(`NVSC_HW_DELAY_US)
// Least time rounds up, at least one cycle
`define NVSC_HW_PULSE_CYC      ((`NVSC_HW_PULSE_NS * 20 + 999) / 1000)

// Command addresses (low 16 address lines)
`define NVSC_SEQ0              16'h4e38
`define NVSC_SEQ1              16'hb1c7
`define NVSC_SEQ2              16'h83e0
`define NVSC_SEQ3              16'h7c1f
`define NVSC_SEQ4              16'h703f
`define NVSC_FIN_STORE         16'h8fc0
`define NVSC_FIN_RECALL        16'h4c63
`define NVSC_FIN_ASDIS         16'h8b45
`define NVSC_FIN_ASEN          16'h4b46

// Bus phase lengths in clocks (50 ns each, covers slowest grade)
`define NVSC_ACC_CYC           2

`endif

// File: rtl/nvsc_host_ctrl.sv
// Behaviour
// - Command sequence issued as CE-controlled reads
// - Six command reads in order, WE high
// - Store/busy line high during ordinary accesses
// - WE held high through every read
// - Store and recall command address sequences
// - Power-loss store disable/enable sequences
`include "nvsc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module nvsc_host_ctrl #(
    parameter int STORE_CYC   = `NVSC_STORE_COM_CYC,
    parameter int POWERUP_CYC = `NVSC_POWERUP_CYC,
    parameter int SEQ_CYC     = `NVSC_SEQ_ACT_CYC,
    parameter int RECALL_CYC  = `NVSC_RECALL_CYC,
    parameter int HWDLY_CYC   = `NVSC_HW_DELAY_CYC
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              reqValid,
    input  wire nvsc_pkg::nvsc_req_s req,
    output logic                   reqReady,
    output logic                   rspValid,
    output logic [7:0]             rspData,
    output logic                   rspSkipped,
    output logic                   dirty,
    output nvsc_pkg::nvsc_bus_s    bus,
    input  wire logic [7:0]        dqIn,
    input  wire logic              hwSaveBusyNIn,
    output logic                   hwSaveBusyNOut,
    output logic                   hwSaveBusyNOe
);
    import nvsc_pkg::*;

    typedef enum logic [3:0] {
        NVSC_ST_BOOT, NVSC_ST_IDLE, NVSC_ST_ACC, NVSC_ST_GAP, NVSC_ST_HWPULSE,
        NVSC_ST_WAIT, NVSC_ST_DONE
    } nvsc_state_e;

    localparam int TW = 20;

    nvsc_state_e  state_reg;
    nvsc_req_s    cur_reg;
    logic [2:0]   seqIdx_reg;
    logic [1:0]   accCnt_reg;
    logic         dirty_reg;
    logic         skipStore_reg;
    logic         busSync0_reg;
    logic         busSync1_reg;
    logic         tmrLoad;
    logic [TW-1:0] tmrCount;
    logic         tmrBusy;
    logic         isCmd;

    function automatic logic [16:0] seqAddr(input logic [2:0] idx, input nvsc_op_e op);
        logic [15:0] a;
        a = `NVSC_SEQ0;
        case (idx)
            3'h0: a = `NVSC_SEQ0;
            3'h1: a = `NVSC_SEQ1;
            3'h2: a = `NVSC_SEQ2;
            3'h3: a = `NVSC_SEQ3;
            3'h4: a = `NVSC_SEQ4;
            default: begin
                case (op)
                    NVSC_OP_STORE:  a = `NVSC_FIN_STORE;
                    NVSC_OP_RECALL: a = `NVSC_FIN_RECALL;
                    NVSC_OP_ASDIS:  a = `NVSC_FIN_ASDIS;
                    default:        a = `NVSC_FIN_ASEN;
                endcase
            end
        endcase
        return {1'b0, a};
    endfunction : seqAddr

    function automatic logic [TW-1:0] opWait(input nvsc_op_e op);
        case (op)
            NVSC_OP_STORE, NVSC_OP_HWSTORE: opWait = TW'(HWDLY_CYC + STORE_CYC);
            NVSC_OP_RECALL: opWait = TW'(SEQ_CYC + RECALL_CYC);
            default:        opWait = TW'(SEQ_CYC);
        endcase
    endfunction : opWait

    assign isCmd = (cur_reg.op != NVSC_OP_READ) && (cur_reg.op != NVSC_OP_WRITE) &&
                   (cur_reg.op != NVSC_OP_HWSTORE);

    nvsc_wait_timer #(.W(TW)) nvsc_wait_timer_inst (
        .clk   (clk),
        .nrst  (nrst),
        .load  (tmrLoad),
        .count (tmrCount),
        .busy  (tmrBusy)
    );

    // Store/busy pin input synchroniser
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busSync0_reg <= 1'b1;
            busSync1_reg <= 1'b1;
        end else begin
            busSync0_reg <= hwSaveBusyNIn;
            busSync1_reg <= busSync0_reg;
        end
    end

    always_comb begin
        tmrLoad  = 1'b0;
        tmrCount = '0;
        if (state_reg == NVSC_ST_BOOT && !tmrBusy && cur_reg.op == NVSC_OP_READ && seqIdx_reg == 3'h7) begin
            tmrLoad  = 1'b1;
            tmrCount = TW'(POWERUP_CYC);
        end else if ((state_reg == NVSC_ST_ACC && isCmd && seqIdx_reg == 3'h5 && accCnt_reg == 2'h0) ||
                     (state_reg == NVSC_ST_HWPULSE && accCnt_reg == 2'h0)) begin
            tmrLoad  = 1'b1;
            tmrCount = opWait(cur_reg.op);
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg  <= NVSC_ST_BOOT;
            cur_reg    <= '0;
            seqIdx_reg <= 3'h7;
            skipStore_reg <= 1'b0;
            accCnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                NVSC_ST_BOOT: begin
                    seqIdx_reg <= 3'h0;
                    if (seqIdx_reg == 3'h0 && !tmrBusy) begin
                        state_reg <= NVSC_ST_IDLE;
                    end
                end
                NVSC_ST_IDLE: begin
                    if (reqValid) begin
                        cur_reg    <= req;
                        // Kept apart: the dirty flag is already clear when a real store ends
                        skipStore_reg <= (req.op == NVSC_OP_STORE) && !dirty_reg;
                        seqIdx_reg <= 3'h0;
                        accCnt_reg <= 2'(`NVSC_ACC_CYC - 1);
                        if (req.op == NVSC_OP_STORE && !dirty_reg) begin
                            state_reg <= NVSC_ST_DONE;
                        end else if (req.op == NVSC_OP_HWSTORE) begin
                            accCnt_reg <= 2'(`NVSC_HW_PULSE_CYC);
                            state_reg  <= NVSC_ST_HWPULSE;
                        end else begin
                            state_reg <= NVSC_ST_ACC;
                        end
                    end
                end
                NVSC_ST_ACC: begin
                    if (accCnt_reg != 2'h0) begin
                        accCnt_reg <= accCnt_reg - 2'h1;
                    end else begin
                        state_reg <= NVSC_ST_GAP;
                    end
                end
                NVSC_ST_GAP: begin
                    accCnt_reg <= 2'(`NVSC_ACC_CYC - 1);
                    if (isCmd && seqIdx_reg != 3'h5) begin
                        seqIdx_reg <= seqIdx_reg + 3'h1;
                        state_reg  <= NVSC_ST_ACC;
                    end else if (isCmd) begin
                        state_reg <= NVSC_ST_WAIT;
                    end else begin
                        state_reg <= NVSC_ST_DONE;
                    end
                end
                NVSC_ST_HWPULSE: begin
                    if (accCnt_reg != 2'h0) begin
                        accCnt_reg <= accCnt_reg - 2'h1;
                    end else begin
                        state_reg <= NVSC_ST_WAIT;
                    end
                end
                NVSC_ST_WAIT: begin
                    if (!tmrBusy && busSync1_reg) begin
                        state_reg <= NVSC_ST_DONE;
                    end
                end
                default: begin
                    state_reg <= NVSC_ST_IDLE;
                end
            endcase
        end
    end

    // Dirty tracking
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dirty_reg <= 1'b0;
        end else if (state_reg == NVSC_ST_ACC && cur_reg.op == NVSC_OP_WRITE) begin
            dirty_reg <= 1'b1;
        end else if (state_reg == NVSC_ST_WAIT && !tmrBusy &&
                     (cur_reg.op == NVSC_OP_STORE || cur_reg.op == NVSC_OP_RECALL ||
                      cur_reg.op == NVSC_OP_HWSTORE)) begin
            dirty_reg <= 1'b0;
        end
    end

    // Pin drive; WE falls after CE so each write has a fresh edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus            <= '{addr: '0, dqOut: '0, dqOe: 1'b0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
            hwSaveBusyNOut <= 1'b1;
            hwSaveBusyNOe  <= 1'b0;
        end else begin
            bus.ceN <= !(state_reg == NVSC_ST_ACC);
            bus.addr <= isCmd ? seqAddr(seqIdx_reg, cur_reg.op) : cur_reg.addr;
            bus.oeN <= !(state_reg == NVSC_ST_ACC && cur_reg.op != NVSC_OP_WRITE);
            bus.weN <= !(state_reg == NVSC_ST_ACC && cur_reg.op == NVSC_OP_WRITE &&
                         accCnt_reg != 2'(`NVSC_ACC_CYC - 1));
            bus.dqOe  <= (state_reg == NVSC_ST_ACC && cur_reg.op == NVSC_OP_WRITE);
            bus.dqOut <= cur_reg.wdata;
            hwSaveBusyNOut <= 1'b0;
            hwSaveBusyNOe  <= (state_reg == NVSC_ST_HWPULSE);
        end
    end

    // User answers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reqReady   <= 1'b0;
            rspValid   <= 1'b0;
            rspData    <= 8'h00;
            rspSkipped <= 1'b0;
            dirty      <= 1'b0;
        end else begin
            reqReady   <= (state_reg == NVSC_ST_IDLE) && !reqValid;
            rspValid   <= (state_reg == NVSC_ST_DONE);
            rspSkipped <= (state_reg == NVSC_ST_DONE) && skipStore_reg;
            dirty      <= dirty_reg;
            if (state_reg == NVSC_ST_ACC && accCnt_reg == 2'h0 && cur_reg.op == NVSC_OP_READ) begin
                rspData <= dqIn;
            end
        end
    end

    a_we_high_read: assert property (@(posedge clk) disable iff (!nrst)
        (!bus.oeN) |-> bus.weN) else $error("WE low during read");
    a_cmd_we_high: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == NVSC_ST_ACC && isCmd) |=> bus.weN) else $error("WE low in command");
    a_hsb_idle: assert property (@(posedge clk) disable iff (!nrst)
        (!bus.ceN) |-> !hwSaveBusyNOe) else $error("Store line low in access");
    a_skip_clean: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == NVSC_ST_IDLE && reqValid && req.op == NVSC_OP_STORE && !dirty_reg)
        |=> state_reg == NVSC_ST_DONE) else $error("Clean store not skipped");
    a_we_after_ce: assert property (@(posedge clk) disable iff (!nrst)
        $fell(bus.ceN) |-> bus.weN) else $error("WE low at CE fall");
    a_port_blocked: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == NVSC_ST_WAIT && tmrBusy) |=> (bus.ceN && bus.oeN && bus.weN && !bus.dqOe))
        else $error("Port used while busy");
    c_write: cover property (@(posedge clk) rspValid && cur_reg.op == NVSC_OP_WRITE);
    c_store: cover property (@(posedge clk) rspValid && cur_reg.op == NVSC_OP_STORE && !rspSkipped);
    c_hw: cover property (@(posedge clk) rspValid && cur_reg.op == NVSC_OP_HWSTORE);
endmodule : nvsc_host_ctrl
`default_nettype wire

// File: rtl/nvsc_pkg.sv
package nvsc_pkg;
    typedef enum logic [2:0] {
        NVSC_OP_READ, NVSC_OP_WRITE, NVSC_OP_STORE, NVSC_OP_RECALL,
        NVSC_OP_ASDIS, NVSC_OP_ASEN, NVSC_OP_HWSTORE
    } nvsc_op_e;

    typedef struct packed {
        nvsc_op_e    op;
        logic [16:0] addr;
        logic [7:0]  wdata;
    } nvsc_req_s;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  dqOut;
        logic        dqOe;
        logic        ceN;
        logic        oeN;
        logic        weN;
    } nvsc_bus_s;
endpackage : nvsc_pkg

// File: rtl/nvsc_wait_timer.sv
`timescale 1ns/10ps
`default_nettype none
module nvsc_wait_timer #(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy
);
    logic [W-1:0] left_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            left_reg <= '0;
        end else if (load) begin
            left_reg <= count;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - W'(1);
        end
    end

    assign busy = (left_reg != '0);
endmodule : nvsc_wait_timer
`default_nettype wire

// File: verif/nv_store_recall_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nv_store_recall_control_tb;
    import nvsc_pkg::*;
    typedef struct {logic chkD; logic chkS; logic [7:0] data; logic skp;} nvsc_exp_s;
    logic        clk = 1'b0, nrst = 1'b0, reqValid = 1'b0;
    nvsc_req_s   req = '0;
    logic        reqReady, rspValid, rspSkipped, dirty, saveOut, saveOe, savePin, busyLow, autoSaveEn;
    logic [7:0]  rspData, dqIn, storeCnt, errCnt;
    nvsc_bus_s   bus;
    nvsc_exp_s   expQ[$];
    nvsc_exp_s   seenE;
    logic [7:0]  shMem [int];
    logic [7:0]  shNv [int];
    logic [16:0] addrs [4];
    logic [15:0] rnd = 16'h001b;
    logic        expDirty = 1'b0, expAs = 1'b1;
    logic [7:0]  expStores = 8'h00;
    int          fails = 0, totalChecks = 0, doneCnt = 0;
    always #25 clk = ~clk;
    // Pull-up on the store/busy line
    assign savePin = (saveOe ? saveOut : 1'b1) & ~busyLow;
    nvsc_host_ctrl #(.STORE_CYC(20), .POWERUP_CYC(20), .SEQ_CYC(20), .RECALL_CYC(20), .HWDLY_CYC(20))
    nvsc_host_ctrl_inst (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .rspSkipped(rspSkipped), .dirty(dirty), .bus(bus),
        .dqIn(dqIn), .hwSaveBusyNIn(savePin), .hwSaveBusyNOut(saveOut), .hwSaveBusyNOe(saveOe));
    nvsc_dev_model nvsc_dev_model_inst (.clk(clk), .nrst(nrst), .bus(bus), .savePin(savePin), .dqIn(dqIn),
        .busyLow(busyLow), .storeCnt(storeCnt), .autoSaveEn(autoSaveEn), .errCnt(errCnt));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("[ERR] %0t unexpected response", $time);
            end else begin
                seenE = expQ.pop_front();
                if (seenE.chkD) check(rspData, seenE.data);
                if (seenE.chkS) check({7'h00, rspSkipped}, {7'h00, seenE.skp});
            end
            doneCnt++;
        end
    end
    task automatic do_op(input nvsc_op_e op, input logic [16:0] a, input logic [7:0] d);
        nvsc_exp_s e;
        int        n;
        int        k;
        e = '{1'b0, op == NVSC_OP_STORE, 8'h00, 1'b0};
        case (op)
            NVSC_OP_WRITE: begin shMem[a] = d; expDirty = 1'b1; end
            NVSC_OP_READ: begin e.chkD = 1'b1; e.data = shMem[a]; end
            NVSC_OP_RECALL: begin shMem = shNv; expDirty = 1'b0; end
            NVSC_OP_ASDIS: expAs = 1'b0;
            NVSC_OP_ASEN: expAs = 1'b1;
            default: begin
                e.skp = !expDirty;
                if (expDirty) begin shNv = shMem; expStores++; end
                expDirty = 1'b0;
            end
        endcase
        for (k = 0; k < 3000 && reqReady !== 1'b1; k++) begin @(posedge clk); #1; end
        expQ.push_back(e);
        n = doneCnt;
        reqValid = 1'b1;
        req = '{op, a, d};
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        for (k = 0; k < 3000 && doneCnt == n; k++) begin @(posedge clk); #1; end
        if (doneCnt == n) begin fails++; $display("[ERR] %0t no response", $time); end
        check(storeCnt, expStores);
        check({7'h00, dirty}, {7'h00, expDirty});
        check({7'h00, autoSaveEn}, {7'h00, expAs});
    endtask : do_op
    initial begin
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        wait (reqReady === 1'b1);
        #1;
        check({7'h00, busyLow}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            addrs[i] = {rnd[3], rnd};
            rnd = lfsr(rnd);
            do_op(NVSC_OP_WRITE, addrs[i], rnd[7:0]);
        end
        for (int i = 0; i < 4; i++) do_op(NVSC_OP_READ, addrs[i], 8'h00);
        $display("test write_read done");
        do_op(NVSC_OP_STORE, addrs[0], 8'h00);
        do_op(NVSC_OP_STORE, addrs[0], 8'h00);
        $display("test store_skip done");
        do_op(NVSC_OP_WRITE, addrs[1], 8'h3c);
        do_op(NVSC_OP_RECALL, addrs[0], 8'h00);
        do_op(NVSC_OP_READ, addrs[1], 8'h00);
        $display("test recall done");
        do_op(NVSC_OP_HWSTORE, addrs[0], 8'h00);
        do_op(NVSC_OP_WRITE, addrs[2], 8'hc3);
        do_op(NVSC_OP_HWSTORE, addrs[0], 8'h00);
        do_op(NVSC_OP_WRITE, addrs[2], 8'h99);
        do_op(NVSC_OP_RECALL, addrs[0], 8'h00);
        do_op(NVSC_OP_READ, addrs[2], 8'h00);
        $display("test hw_store done");
        do_op(NVSC_OP_ASDIS, addrs[0], 8'h00);
        do_op(NVSC_OP_ASEN, addrs[0], 8'h00);
        check(errCnt, 8'h00);
        $display("test autosave_cmds done");
        stop_test();
    end
    initial begin
        #1000000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule : nv_store_recall_control_tb
`default_nettype wire

// File: verif/nvsc_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_defs.svh"
module nvsc_dev_model #(
    parameter int BUSY_CYC = 6
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire nvsc_pkg::nvsc_bus_s bus,
    input  wire logic                savePin,
    output logic [7:0]               dqIn,
    output logic                     busyLow,
    output logic [7:0]               storeCnt,
    output logic                     autoSaveEn,
    output logic [7:0]               errCnt
);
    import nvsc_pkg::*;
    logic [7:0]  mem [131072];
    logic [7:0]  nv [131072];
    logic [15:0] seqTab [5] = '{`NVSC_SEQ0, `NVSC_SEQ1, `NVSC_SEQ2, `NVSC_SEQ3, `NVSC_SEQ4};
    logic [2:0]  seqIdx;
    logic [7:0]  busyCnt, wrData, dirtyDev;
    logic [7:0]  junk = 8'h5a;
    logic [16:0] accAddr, wrAddr;
    logic        prevCeN, prevWeN, prevSave, wrAct, accWr, weAtCe;
    // Undriven data lines flip every cycle
    assign dqIn = (!bus.ceN && !bus.oeN && bus.weN && !weAtCe && busyCnt == 8'h00) ? mem[bus.addr] : junk;
    assign busyLow = busyCnt != 8'h00;
    always @(posedge clk) begin
        prevCeN  <= bus.ceN;
        prevWeN  <= bus.weN;
        prevSave <= savePin;
        junk     <= ~junk;
        if (!nrst) begin
            seqIdx     <= 3'd0;
            busyCnt    <= BUSY_CYC[7:0];
            wrAct      <= 1'b0;
            weAtCe     <= 1'b0;
            dirtyDev   <= 8'h00;
            storeCnt   <= 8'h00;
            autoSaveEn <= 1'b1;
            errCnt     <= 8'h00;
        end else begin
            if (busyCnt != 8'h00) busyCnt <= busyCnt - 8'h01;
            if (!bus.ceN && !savePin) errCnt <= errCnt + 8'h01;
            if (prevCeN && !bus.ceN) begin
                weAtCe  <= !bus.weN;
                accWr   <= 1'b0;
                accAddr <= bus.addr;
            end
            if (!bus.ceN && !bus.weN) accWr <= 1'b1;
            // Write armed only by a fresh falling edge
            if (!bus.ceN && !bus.weN && (prevCeN || prevWeN) && busyCnt == 8'h00) wrAct <= 1'b1;
            if (!bus.ceN && !bus.weN && bus.dqOe) begin
                wrAddr <= bus.addr;
                wrData <= bus.dqOut;
            end
            if (prevSave && !savePin && !busyLow && dirtyDev[0]) begin
                nv       <= mem;
                dirtyDev <= 8'h00;
                storeCnt <= storeCnt + 8'h01;
                busyCnt  <= BUSY_CYC[7:0];
            end else if (wrAct && (bus.ceN || bus.weN)) begin
                mem[wrAddr] <= wrData;
                dirtyDev    <= 8'h01;
                wrAct       <= 1'b0;
                seqIdx      <= 3'd0;
            end else if (!prevCeN && bus.ceN && !accWr) begin
                if (seqIdx == 3'd5) begin
                    seqIdx <= 3'd0;
                    case (accAddr[15:0])
                        `NVSC_FIN_STORE: if (dirtyDev[0]) begin
                            nv       <= mem;
                            dirtyDev <= 8'h00;
                            storeCnt <= storeCnt + 8'h01;
                            busyCnt  <= BUSY_CYC[7:0];
                        end
                        `NVSC_FIN_RECALL: begin
                            mem      <= nv;
                            dirtyDev <= 8'h00;
                            busyCnt  <= BUSY_CYC[7:0];
                        end
                        `NVSC_FIN_ASDIS: autoSaveEn <= 1'b0;
                        `NVSC_FIN_ASEN: autoSaveEn <= 1'b1;
                        default: ;
                    endcase
                end else if (accAddr[15:0] == seqTab[seqIdx]) seqIdx <= seqIdx + 3'd1;
                else seqIdx <= (accAddr[15:0] == `NVSC_SEQ0) ? 3'd1 : 3'd0;
            end
        end
    end
endmodule : nvsc_dev_model
`default_nettype wire
